/* bpd_bridge_model.sv */
/*
 * Behavioural model of the external bridge switch drivers.
 * Assumes each pin carries a pull-down that keeps its power switch off.
 */
`timescale 1ns/1ps
`default_nettype none
module bpd_bridge_model (
    input  wire bpd_pkg::bpd_pins_t pin_out,
    input  wire bpd_pkg::bpd_pins_t pin_oe_n,
    output bpd_pkg::bpd_pins_t      line
);
    import bpd_pkg::*;

    // released pins fall to the pull-down level, never the last value
    assign line = pin_out & ~pin_oe_n;
endmodule
`default_nettype wire

/* bpd_pkg.sv */
/*
 * Package for the bridge PWM dead band and shutdown stage: register
 * offsets, field positions, reset values, encodings and the carriers.
 * Assumes a single 20 MHz system clock and a plain strobe register port.
 */
`default_nettype none
package bpd_pkg;
    localparam logic [7:0] REG_CFG_OFS   = 8'h16;
    localparam logic [7:0] REG_SHDN_OFS  = 8'h17;
    localparam logic [7:0] REG_CTRL_OFS  = 8'h18;
    localparam logic [7:0] REG_STAT_OFS  = 8'h19;
    localparam logic [7:0] CFG_RESET     = 8'h00;
    localparam logic [7:0] SHDN_RESET    = 8'h00;
    localparam logic [7:0] CTRL_RESET    = 8'h00;
    localparam int         CFG_RESTART_BIT  = 7;
    localparam int         SHDN_STATUS_BIT  = 7;
    localparam int         SRC_HI = 6;
    localparam int         SRC_LO = 4;
    localparam int         AC_HI  = 3;
    localparam int         AC_LO  = 2;
    localparam int         BD_HI  = 1;
    localparam int         BD_LO  = 0;
    localparam int         DT_W   = 7;
    localparam int         TCY_DIV = 4;
    localparam logic [1:0] TCY_LAST = 2'h3;
    localparam logic [1:0] SST_LOW  = 2'h0;
    localparam logic [1:0] SST_HIGH = 2'h1;

    typedef struct packed {
        logic a;
        logic b;
        logic c;
        logic d;
    } bpd_pins_t;

    typedef struct packed {
        logic cmp1;
        logic cmp2;
        logic ext_int_n;
    } bpd_fault_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bpd_bus_t;
endpackage
`default_nettype wire

/* bpd_top.sv */
/*
 * Dead band insertion, polarity and auto-shutdown for a bridge PWM stage.
 * Assumes raw PWM, period-start pulse, sleep and comparator levels are
 * synchronous to clk; the period timer itself lives outside.
 */
`timescale 1ns/1ps
`default_nettype none
module bpd_top #(
    parameter int DT_WIDTH = bpd_pkg::DT_W
) (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire bpd_pkg::bpd_bus_t bus,
    output logic [7:0]             rdata,
    input  wire logic              pwm_raw,
    input  wire logic              period_start,
    input  wire logic              sleep,
    input  wire bpd_pkg::bpd_fault_t fault,
    output bpd_pkg::bpd_pins_t     pin_out,
    output bpd_pkg::bpd_pins_t     pin_oe_n,
    output logic                   period_timer_flag
);
    import bpd_pkg::*;

    logic [7:0]          cfg_q;
    logic [7:0]          shdn_q;
    logic [7:0]          ctrl_q;
    logic [1:0]          tcy_q;
    logic                tcy_en;
    logic                run;
    logic                cause;
    logic                status_wr;
    logic                outputs_held_q;
    logic [1:0]          periods_q;
    logic [DT_WIDTH-1:0] dly_a_q;
    logic [DT_WIDTH-1:0] dly_b_q;
    logic                del_a_q;
    logic                del_b_q;
    logic                prev_a_q;
    logic                prev_b_q;
    logic [7:0]          rdata_q;
    bpd_pins_t           norm_val;
    bpd_pins_t           norm_oe_n;

    // ctrl: bit0/1 polarity A/C, B/D (1 = active low); bit2 half-bridge;
    // bits 7..4 pin enables (1 = pins drive): bit 7 = a down to bit 4 = d
    wire logic [1:0] output_polarity_select = ctrl_q[1:0];
    wire logic       half_bridge_en         = ctrl_q[2];
    wire logic [3:0] pin_drive_en           = ctrl_q[7:4];
    wire logic       restart_enable         = cfg_q[CFG_RESTART_BIT];
    wire logic [DT_WIDTH-1:0] dead_time_count = DT_WIDTH'(cfg_q[DT_W-1:0]);
    wire logic [2:0] shutdown_source_select = shdn_q[SRC_HI:SRC_LO];
    wire logic [1:0] pair_a_c_shutdown_state = shdn_q[AC_HI:AC_LO];
    wire logic [1:0] pair_b_d_shutdown_state = shdn_q[BD_HI:BD_LO];
    wire logic       shutdown_status        = shdn_q[SHDN_STATUS_BIT];

    assign run    = ~sleep;
    assign tcy_en = run && (tcy_q == TCY_LAST);

    // one instruction cycle every four clocks; clock switching on failure
    // is done by the clock tree ahead of clk, this block only sees clk
    always_ff @(posedge clk)
    begin
        if (srst)
            tcy_q <= 2'h0;
        else if (run)
            tcy_q <= tcy_q + 2'h1;
    end

    // level cause from the selected sources
    always_comb
    begin
        cause = 1'b0;
        if (shutdown_source_select[0] && fault.cmp1)
            cause = 1'b1;
        if (shutdown_source_select[1] && fault.cmp2)
            cause = 1'b1;
        if (shutdown_source_select[2] && !fault.ext_int_n)
            cause = 1'b1;
    end

    assign status_wr = bus.wr && (bus.addr == REG_SHDN_OFS);

    always_ff @(posedge clk)
    begin
        if (srst)
            cfg_q <= CFG_RESET;
        else if (bus.wr && bus.addr == REG_CFG_OFS)
            cfg_q <= bus.wdata;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            ctrl_q <= CTRL_RESET;
        else if (bus.wr && bus.addr == REG_CTRL_OFS)
            ctrl_q <= bus.wdata;
    end

    // set beats clear; software writes to status blocked while a cause lasts
    always_ff @(posedge clk)
    begin
        if (srst)
            shdn_q <= SHDN_RESET;
        else
        begin
            if (status_wr)
                shdn_q[SRC_HI:0] <= bus.wdata[SRC_HI:0];
            if (cause)
                shdn_q[SHDN_STATUS_BIT] <= 1'b1;
            else if (status_wr)
                shdn_q[SHDN_STATUS_BIT] <= bus.wdata[SHDN_STATUS_BIT];
            else if (restart_enable && run)
                shdn_q[SHDN_STATUS_BIT] <= 1'b0;
        end
    end

    // outputs stay in shutdown until a period boundary after status drops
    always_ff @(posedge clk)
    begin
        if (srst)
            outputs_held_q <= 1'b0;
        else if (shutdown_status || cause)
            outputs_held_q <= 1'b1;
        else if (period_start && run)
            outputs_held_q <= 1'b0;
    end

    // flag marks second period start, i.e. first full cycle done
    always_ff @(posedge clk)
    begin
        if (srst)
            periods_q <= 2'h0;
        else if (period_start && run && periods_q != 2'h2)
            periods_q <= periods_q + 2'h1;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            period_timer_flag <= 1'b0;
        else if (bus.wr && bus.addr == REG_STAT_OFS && !bus.wdata[0])
            period_timer_flag <= 1'b0;
        if (!srst && period_start && run && periods_q == 2'h1)
            period_timer_flag <= 1'b1;
    end

    // dead band: rising edge of a channel reloads the counter, channel
    // goes active only once it reaches zero; falling edges pass at once
    wire logic lvl_a = pwm_raw;
    wire logic lvl_b = ~pwm_raw;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            prev_a_q <= 1'b0;
            prev_b_q <= 1'b0;
            dly_a_q  <= '0;
            dly_b_q  <= '0;
            del_a_q  <= 1'b0;
            del_b_q  <= 1'b0;
        end
        else if (run)
        begin
            prev_a_q <= lvl_a;
            prev_b_q <= lvl_b;
            if (!lvl_a)
                del_a_q <= 1'b0;
            else if (!prev_a_q)
            begin
                dly_a_q <= dead_time_count;
                del_a_q <= (dead_time_count == '0);
            end
            else if (dly_a_q == '0)
                del_a_q <= 1'b1;
            else if (tcy_en)
                dly_a_q <= dly_a_q - DT_WIDTH'(1);
            if (!lvl_b)
                del_b_q <= 1'b0;
            else if (!prev_b_q)
            begin
                dly_b_q <= dead_time_count;
                del_b_q <= (dead_time_count == '0);
            end
            else if (dly_b_q == '0)
                del_b_q <= 1'b1;
            else if (tcy_en)
                dly_b_q <= dly_b_q - DT_WIDTH'(1);
        end
    end

    // normal drive with polarity; full-bridge steering is outside, so
    // without half-bridge the raw signal feeds all four pins
    always_comb
    begin
        norm_val.a = (half_bridge_en ? del_a_q : pwm_raw) ^ output_polarity_select[0];
        norm_val.c = pwm_raw ^ output_polarity_select[0];
        norm_val.b = (half_bridge_en ? del_b_q : pwm_raw) ^ output_polarity_select[1];
        norm_val.d = pwm_raw ^ output_polarity_select[1];
        norm_oe_n  = bpd_pins_t'(~pin_drive_en);
    end

    // combinational override so the fault reaches the pins without a clock
    always_comb
    begin
        pin_out  = norm_val;
        pin_oe_n = norm_oe_n;
        if (outputs_held_q || shutdown_status || cause)
        begin
            pin_out.a = (pair_a_c_shutdown_state == SST_HIGH);
            pin_out.c = (pair_a_c_shutdown_state == SST_HIGH);
            pin_out.b = (pair_b_d_shutdown_state == SST_HIGH);
            pin_out.d = (pair_b_d_shutdown_state == SST_HIGH);
            if (pair_a_c_shutdown_state[1])
            begin
                pin_oe_n.a = 1'b1;
                pin_oe_n.c = 1'b1;
            end
            if (pair_b_d_shutdown_state[1])
            begin
                pin_oe_n.b = 1'b1;
                pin_oe_n.d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            rdata_q <= 8'h00;
        else if (bus.rd)
            case (bus.addr)
                REG_CFG_OFS:  rdata_q <= cfg_q;
                REG_SHDN_OFS: rdata_q <= shdn_q;
                REG_CTRL_OFS: rdata_q <= ctrl_q;
                REG_STAT_OFS: rdata_q <= {6'h00, outputs_held_q, period_timer_flag};
                default:      rdata_q <= 8'h00;
            endcase
        else
            rdata_q <= 8'h00;
    end
    assign rdata = rdata_q;

    AST_CAUSE_SETS_STATUS: assert property (@(posedge clk) disable iff (srst)
        cause |=> shutdown_status)
        else $error("status not set after cause");
    AST_FORCE_IMMEDIATE: assert property (@(posedge clk) disable iff (srst)
        (cause && pair_a_c_shutdown_state == SST_LOW) |-> (!pin_out.a && !pin_out.c))
        else $error("pair a/c not forced low");
    AST_TRISTATE_BD: assert property (@(posedge clk) disable iff (srst)
        (shutdown_status && pair_b_d_shutdown_state[1]) |-> (pin_oe_n.b && pin_oe_n.d))
        else $error("pair b/d not released");
    AST_NO_AUTOCLEAR: assert property (@(posedge clk) disable iff (srst)
        (shutdown_status && !restart_enable && !status_wr) |=> shutdown_status)
        else $error("status cleared without software");
    AST_AUTO_RESTART: assert property (@(posedge clk) disable iff (srst)
        (shutdown_status && restart_enable && !cause && !status_wr && run) |=> !shutdown_status)
        else $error("auto restart missing");
    AST_RESUME_AT_PERIOD: assert property (@(posedge clk) disable iff (srst)
        ($fell(shutdown_status) && !period_start) |-> outputs_held_q)
        else $error("resumed before period start");
    AST_FALL_NOT_DELAYED: assert property (@(posedge clk) disable iff (srst)
        (run && !lvl_a) |=> !del_a_q)
        else $error("falling edge delayed");
    AST_ZERO_DEADBAND: assert property (@(posedge clk) disable iff (srst)
        (run && lvl_a && !prev_a_q && dead_time_count == '0) |=> del_a_q)
        else $error("zero dead band added delay");
    AST_SLEEP_FREEZE: assert property (@(posedge clk) disable iff (srst)
        sleep |=> $stable(tcy_q) && $stable(dly_a_q))
        else $error("state moved in sleep");
    AST_RESET_VALUES: assert property (@(posedge clk)
        srst |=> (cfg_q == CFG_RESET && shdn_q == SHDN_RESET))
        else $error("register reset value wrong");

    // named steps of the dead band and of the release path
    sequence seq_rise_a;
        run && lvl_a && !prev_a_q;
    endsequence

    sequence seq_counting_a;
        run && lvl_a && prev_a_q && dly_a_q != '0;
    endsequence

    sequence seq_held_no_cause;
        outputs_held_q && !shutdown_status && !cause;
    endsequence

    sequence seq_period_edge;
        period_start && run;
    endsequence

    AST_DEADBAND_LOAD: assert property (@(posedge clk) disable iff (srst)
        seq_rise_a |=> dly_a_q == $past(dead_time_count))
        else $error("dead band count not loaded on rising edge");

    // counter moves only on the instruction enable, one step at a time
    AST_COUNT_STEP: assert property (@(posedge clk) disable iff (srst)
        (seq_counting_a ##0 tcy_en) |=> dly_a_q == $past(dly_a_q) - DT_WIDTH'(1))
        else $error("dead band counter missed a step");

    AST_COUNT_WAITS: assert property (@(posedge clk) disable iff (srst)
        (seq_counting_a ##0 !tcy_en) |=> $stable(dly_a_q))
        else $error("dead band counter moved between instruction cycles");

    // a nonzero count means the channel is still held off
    AST_DEADBAND_HOLDS_OFF: assert property (@(posedge clk) disable iff (srst)
        (dly_a_q == '0 || !del_a_q) && (dly_b_q == '0 || !del_b_q))
        else $error("channel active before dead band ran out");

    // both switches of one leg on at once would short the supply
    AST_NO_SHOOT_THROUGH: assert property (@(posedge clk) disable iff (srst)
        !(del_a_q && del_b_q))
        else $error("both half-bridge channels active");

    AST_HIGH_STATE_AC: assert property (@(posedge clk) disable iff (srst)
        (cause && pair_a_c_shutdown_state == SST_HIGH) |-> (pin_out.a && pin_out.c))
        else $error("pair a/c not forced high");

    AST_PIN_SOURCE_SETS: assert property (@(posedge clk) disable iff (srst)
        (shutdown_source_select[2] && !fault.ext_int_n) |=> shutdown_status)
        else $error("pin source did not set status");

    AST_WRITE_BLOCKED: assert property (@(posedge clk) disable iff (srst)
        (cause && status_wr) |=> shutdown_status)
        else $error("status write taken during active cause");

    AST_SOFT_FORCE: assert property (@(posedge clk) disable iff (srst)
        (status_wr && bus.wdata[SHDN_STATUS_BIT]) |=> shutdown_status)
        else $error("software force did not set status");

    AST_FLAG_SECOND_PERIOD: assert property (@(posedge clk) disable iff (srst)
        (seq_period_edge ##0 periods_q == 2'h1) |=> period_timer_flag)
        else $error("period flag not set at second period");

    AST_FLAG_NOT_EARLY: assert property (@(posedge clk) disable iff (srst)
        (periods_q != 2'h2) |-> !period_timer_flag)
        else $error("period flag set before second period");

    // shutdown may only release pins, never enable them
    AST_PINS_RELEASED: assert property (@(posedge clk) disable iff (srst)
        (pin_drive_en == 4'h0) |-> (pin_oe_n == bpd_pins_t'(4'hf)))
        else $error("pin driven while not enabled");

    AST_HOLD_UNTIL_PERIOD: assert property (@(posedge clk) disable iff (srst)
        (outputs_held_q && !period_start) |=> outputs_held_q)
        else $error("outputs released without period start");

    AST_RELEASE_AT_PERIOD: assert property (@(posedge clk) disable iff (srst)
        (seq_held_no_cause ##0 seq_period_edge) |=> !outputs_held_q)
        else $error("outputs not released at period start");
endmodule
`default_nettype wire

/* tb_bridge_pwm_deadband_shutdown.sv */
/*
 * Self-checking testbench for the bridge PWM dead band and shutdown stage.
 * Assumes bpd_pkg, bpd_top and bpd_bridge_model are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_bridge_pwm_deadband_shutdown;
    import bpd_pkg::*;
    logic       clk = 1'b0;
    logic       srst = 1'b1;
    bpd_bus_t   bus = '0;
    logic [7:0] rdata;
    logic       pwm_raw = 1'b0;
    logic       period_start = 1'b0;
    logic       sleep = 1'b0;
    bpd_fault_t fault = 3'b001;
    bpd_pins_t  pin_out;
    bpd_pins_t  pin_oe_n;
    bpd_pins_t  line;
    logic       flag;
    int         errors = 0;
    int         comparisons = 0;
    int         cyc = 0;

    always #25 clk = ~clk;

    bpd_top uut (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata), .pwm_raw(pwm_raw),
        .period_start(period_start), .sleep(sleep), .fault(fault), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .period_timer_flag(flag));
    bpd_bridge_model drv (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .line(line));

    task automatic end_sim;
        if (errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            end_sim;
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic pstart;
        @(posedge clk);
        period_start <= 1'b1;
        @(posedge clk);
        period_start <= 1'b0;
        #1;
    endtask

    task automatic setf(input bpd_fault_t f);
        @(posedge clk);
        fault <= f;
        #1;
    endtask

    // cycles until the delayed output goes active, bounded
    task automatic meas(input logic b, input int lo, input int hi);
        int n;
        n = 0;
        #1;
        while ((b ? line.b : line.a) !== 1'b1 && n < 600)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(8'(n >= lo && n <= hi), 8'h01);
    endtask

    task automatic t_reset;
        tick(1);
        chk(8'(pin_oe_n), 8'h0f);
        rd(8'h16, 8'h00);
        rd(8'h17, 8'h00);
        rd(8'h30, 8'h00);
    endtask

    task automatic t_flag;
        wr(8'h18, 8'h04);
        chk(8'(flag), 8'h00);
        pstart;
        chk(8'(flag), 8'h00);
        pstart;
        chk(8'(flag), 8'h01);
        rd(8'h19, 8'h01);
        wr(8'h19, 8'h00);
        rd(8'h19, 8'h00);
        wr(8'h18, 8'hf4);
    endtask

    task automatic t_dead;
        wr(8'h16, 8'h05);
        repeat (4) @(posedge clk);
        pwm_raw <= 1'b1;
        meas(1'b0, 17, 24);
        @(posedge clk);
        pwm_raw <= 1'b0;
        tick(2);
        chk(8'(line.a), 8'h00);
        meas(1'b1, 15, 22);
        wr(8'h16, 8'h00);
        repeat (2) @(posedge clk);
        pwm_raw <= 1'b1;
        meas(1'b0, 0, 2);
        chk(8'(line.b), 8'h00);
        @(posedge clk);
        pwm_raw <= 1'b0;
        tick(3);
    endtask

    task automatic t_long;
        logic hit;
        hit = 1'b0;
        wr(8'h16, 8'h14);
        @(posedge clk);
        pwm_raw <= 1'b1;
        repeat (40)
        begin
            @(posedge clk);
            #1;
            hit |= line.a;
        end
        @(posedge clk);
        pwm_raw <= 1'b0;
        chk(8'(hit), 8'h00);
        tick(100);
    endtask

    task automatic t_sleep;
        wr(8'h16, 8'h05);
        @(posedge clk);
        sleep <= 1'b1;
        pwm_raw <= 1'b1;
        tick(40);
        chk(8'(line.a), 8'h00);
        @(posedge clk);
        sleep <= 1'b0;
        meas(1'b0, 17, 24);
        @(posedge clk);
        pwm_raw <= 1'b0;
        tick(30);
        wr(8'h16, 8'h00);
    endtask

    // in the loop, polarity is changed only while the pins are released
    task automatic t_polar;
        for (int p = 0; p < 3; p++)
        begin
            wr(8'h18, 8'(4 + p));
            wr(8'h18, 8'(8'hf4 + p));
            pstart;
            tick(4);
            chk(8'({line.a, line.b}), 8'(p == 0 ? 1 : p == 1 ? 3 : 0));
        end
        wr(8'h18, 8'hf0);
        @(posedge clk);
        pwm_raw <= 1'b1;
        tick(2);
        chk(8'(line), 8'h0f);
        @(posedge clk);
        pwm_raw <= 1'b0;
        wr(8'h18, 8'h04);
        wr(8'h18, 8'hf4);
    endtask

    task automatic t_auto;
        bpd_fault_t c;
        logic       s;
        wr(8'h16, 8'h80);
        for (int src = 0; src < 8; src++)
            for (int k = 0; k < 3; k++)
            begin
                c = k == 0 ? 3'b101 : k == 1 ? 3'b011 : 3'b000;
                s = src[k];
                wr(8'h17, 8'(src * 16 + 4));
                setf(c);
                chk(8'({line.a, line.b}), s ? 8'h02 : 8'h01);
                if (s)
                    chk(8'({line.c, line.d}), 8'h02);
                rd(8'h17, 8'(s * 128 + src * 16 + 4));
                setf(3'b001);
                rd(8'h17, 8'(src * 16 + 4));
                chk(8'({line.a, line.b}), s ? 8'h02 : 8'h01);
                pstart;
                tick(1);
                chk(8'({line.a, line.b}), 8'h01);
            end
    endtask

    task automatic t_manual;
        wr(8'h16, 8'h00);
        wr(8'h17, 8'h10);
        setf(3'b101);
        wr(8'h17, 8'h10);
        rd(8'h17, 8'h90);
        setf(3'b001);
        rd(8'h17, 8'h90);
        wr(8'h17, 8'h10);
        rd(8'h17, 8'h10);
        chk(8'({line.a, line.b}), 8'h00);
        pstart;
        tick(1);
        chk(8'({line.a, line.b}), 8'h01);
        wr(8'h17, 8'h8e);
        tick(1);
        chk(8'(pin_oe_n), 8'h0f);
        chk(8'(line), 8'h00);
        rd(8'h17, 8'h8e);
        rd(8'h19, 8'h02);
        wr(8'h17, 8'h0e);
        pstart;
        tick(1);
        chk(8'({pin_oe_n.a, pin_oe_n.b}), 8'h00);
        wr(8'h18, 8'h84);
        tick(1);
        chk(8'(pin_oe_n), 8'h07);
    endtask

    initial
    begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        t_reset;
        t_flag;
        t_dead;
        t_long;
        t_sleep;
        t_polar;
        t_auto;
        t_manual;
        end_sim;
    end
endmodule
`default_nettype wire
